// ### verilog/swb_ctrl.sv
/*
 SRAM write-back controller: local-bus slave with a one-entry write buffer.
 Assumes a single-cycle request strobe from logic on the same clock.
*/
// Summary of operation
// - Byte, halfword and word accesses touch only their addressed lanes.
// - Capacity is a parameter of 64, 32 or 16 kilobytes and decoding covers just that.
// - The latest in-range write is held in a one-entry buffer and accepted at once.
// - The buffered write reaches the array only when the next write arrives.
// - Back-to-back writes complete on successive cycles without wait states.
// - Reset discards the pending buffered write without flushing it.
// - Lanes are little-endian, lowest address byte in the low bits.
`timescale 1ns/10ps
`include "swb_regs.svh"

module swb_ctrl
  import swb_pkg::*;
#(
  parameter int SIZE_KB = `SWB_SIZE_64K
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic req_i,
  input wire swb_req_s req_data_i,
  output logic ready_o,
  output logic rvalid_o,
  output logic [31:0] rdata_o,
  output logic err_o
);

  localparam int AW = $clog2(SIZE_KB * 1024) - 2;

  typedef enum logic {SWB_IDLE, SWB_RDWAIT} swb_state_e;

  // -----------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------
  function automatic logic [3:0] lane_mask(input swb_size_e sz, input logic [1:0] a);
    logic [3:0] m;
    m = 4'h0;
    case (sz)
      SWB_BYTE: m = 4'h1 << a;
      SWB_HALF: m = a[1] ? 4'hC : 4'h3;
      SWB_WORD: m = 4'hF;
      default: m = 4'h0;
    endcase
    return m;
  endfunction

  function automatic logic [31:0] lane_data(input swb_size_e sz, input logic [31:0] d);
    logic [31:0] r;
    r = 32'h0;
    case (sz)
      SWB_BYTE: r = {4{d[7:0]}};
      SWB_HALF: r = {2{d[15:0]}};
      default: r = d;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] a, input logic [31:0] b,
                                        input logic [3:0] m);
    logic [31:0] r;
    r = a;
    for (int i = 0; i < 4; i++) begin
      if (m[i]) begin
        r[8*i +: 8] = b[8*i +: 8];
      end
    end
    return r;
  endfunction

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  swb_wbuf_s wbuf_r, wbuf_nxt;
  swb_state_e state_r, state_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic err_r, err_nxt;
  logic [3:0] hit_lanes_r, hit_lanes_nxt;
  logic [31:0] hit_data_r, hit_data_nxt;
  logic in_range;
  logic [3:0] lanes;
  logic ram_ce, ram_we;
  logic [3:0] ram_be;
  logic [AW-1:0] ram_addr;
  logic [31:0] ram_wdata, ram_rdata;
  logic [31:0] req_wdata;
  logic take, take_wr, take_rd, bad, hit;

  assign lanes = lane_mask(req_data_i.size, req_data_i.addr[1:0]);
  assign req_wdata = lane_data(req_data_i.size, req_data_i.wdata);
  assign in_range = (req_data_i.addr[31:AW+2] == '0);
  assign ready_o = (state_r == SWB_IDLE);
  assign rvalid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign err_o = err_r;

  // -----------------------------------------------------------------------
  // Request decode
  // -----------------------------------------------------------------------
  assign take = req_i && ready_o;
  assign bad = take && !in_range;
  assign take_wr = take && in_range && req_data_i.write;
  assign take_rd = take && in_range && !req_data_i.write;
  assign hit = wbuf_r.valid && (wbuf_r.addr[AW+1:2] == req_data_i.addr[AW+1:2]);

  // -----------------------------------------------------------------------
  // Array port
  // -----------------------------------------------------------------------
  always_comb begin
    ram_ce = 1'b0;
    ram_we = 1'b0;
    ram_be = 4'h0;
    ram_addr = req_data_i.addr[AW+1:2];
    ram_wdata = wbuf_r.data;
    if (take_wr && wbuf_r.valid) begin
      ram_ce = 1'b1;
      ram_we = 1'b1;
      ram_be = wbuf_r.lanes;
      ram_addr = wbuf_r.addr[AW+1:2];
    end else if (take_rd) begin
      ram_ce = 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // Write buffer
  // -----------------------------------------------------------------------
  always_comb begin
    wbuf_nxt = wbuf_r;
    if (take_wr) begin
      wbuf_nxt.valid = 1'b1;
      wbuf_nxt.addr = req_data_i.addr;
      wbuf_nxt.data = req_wdata;
      wbuf_nxt.lanes = lanes;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wbuf_r <= '0;
    end else if (ce_i) begin
      wbuf_r <= wbuf_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    hit_lanes_nxt = hit_lanes_r;
    hit_data_nxt = hit_data_r;
    case (state_r)
      SWB_IDLE: begin
        if (bad && !req_data_i.write) begin
          rvalid_nxt = 1'b1;
          rdata_nxt = 32'h0;
        end else if (take_rd) begin
          state_nxt = SWB_RDWAIT;
          hit_lanes_nxt = hit ? wbuf_r.lanes : 4'h0;
          hit_data_nxt = wbuf_r.data;
        end
      end
      SWB_RDWAIT: begin
        rdata_nxt = merge(ram_rdata, hit_data_r, hit_lanes_r);
        rvalid_nxt = 1'b1;
        state_nxt = SWB_IDLE;
      end
      default: state_nxt = SWB_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= SWB_IDLE;
      rdata_r <= 32'h0;
      rvalid_r <= 1'b0;
      hit_lanes_r <= 4'h0;
      hit_data_r <= 32'h0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      hit_lanes_r <= hit_lanes_nxt;
      hit_data_r <= hit_data_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // Range error
  // -----------------------------------------------------------------------
  always_comb begin
    err_nxt = bad;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_r <= 1'b0;
    end else if (ce_i) begin
      err_r <= err_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // Array
  // -----------------------------------------------------------------------
  swb_ram #(
    .AW(AW)
  ) u_ram (
    .clk_i(clk_i),
    .ce_i(ram_ce && ce_i && !rst_i),
    .we_i(ram_we),
    .be_i(ram_be),
    .addr_i(ram_addr),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

endmodule

// ### shared/swb_regs.svh
/*
 Timing and layout constants for the SRAM write-back controller.
 Assumes inclusion from the package and design modules only.
*/
`ifndef SWB_REGS_SVH
`define SWB_REGS_SVH

// -----------------------------------------------------------------------
// Capacity, lanes and read latency
// -----------------------------------------------------------------------
`define SWB_SIZE_64K 64
`define SWB_SIZE_32K 32
`define SWB_SIZE_16K 16
`define SWB_LANES 4
`define SWB_READ_LATENCY 1

`endif

// ### shared/swb_pkg.sv
/*
 Types for the SRAM write-back controller.
 Assumes the constants header is on the include path.
*/
`include "swb_regs.svh"

package swb_pkg;

  // -----------------------------------------------------------------------
  // Access size, request and write-buffer entry
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SWB_BYTE = 2'h0,
    SWB_HALF = 2'h1,
    SWB_WORD = 2'h2
  } swb_size_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    swb_size_e size;
    logic write;
  } swb_req_s;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] lanes;
  } swb_wbuf_s;

endpackage

// ### verilog/swb_ram.sv
/*
 Word-wide single-port memory with byte-lane write enables.
 Assumes one clock; read data is registered.
*/
`timescale 1ns/10ps

module swb_ram #(
  parameter int AW = 14
) (
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [3:0] be_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);

  logic [31:0] mem [0:(1<<AW)-1];

  // -----------------------------------------------------------------------
  // Array access
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        for (int i = 0; i < 4; i++) begin
          if (be_i[i]) begin
            mem[addr_i][8*i +: 8] <= wdata_i[8*i +: 8];
          end
        end
      end else begin
        rdata_o <= mem[addr_i];
      end
    end
  end

endmodule

// ### test/swb_ctrl_checker.sv
/* Port assertions for the controller; assumes ce_i held high. */
`timescale 1ns/10ps

module swb_ctrl_checker
  import swb_pkg::*;
#(
  parameter int SIZE_KB = 64
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic req_i,
  input wire swb_req_s req_data_i,
  input wire logic ready_o,
  input wire logic rvalid_o,
  input wire logic [31:0] rdata_o,
  input wire logic err_o
);
  // --
  // Checks
  // --
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic tk;
  logic rdk;
  logic inr;
  assign tk = ce_i && req_i && ready_o;
  assign rdk = tk && !req_data_i.write;
  assign inr = req_data_i.addr < SIZE_KB * 1024;
  AST_WR_NOWAIT: assert property (tk && req_data_i.write |=> ready_o)
    else $error("write stall");
  AST_BUSY_CAUSE: assert property (!ready_o |-> $past(rdk))
    else $error("busy");
  AST_RD_TIME: assert property (rdk && inr |=> !ready_o ##1 rvalid_o && ready_o)
    else $error("read");
  AST_RV_CAUSE: assert property (rvalid_o && !err_o |-> $past(rdk && inr, 2))
    else $error("rvalid");
  AST_OOR_ERR: assert property (tk && !inr |=> err_o)
    else $error("no err");
  AST_INR_OK: assert property (tk && inr |=> !err_o)
    else $error("err");
  AST_OOR_ZERO: assert property (err_o && rvalid_o |-> rdata_o == 32'h0)
    else $error("data");
  AST_OOR_RV: assert property (rdk && !inr |=> rvalid_o && err_o)
    else $error("no answer");
  AST_RST_IDLE: assert property (disable iff (1'h0)
    rst_i |=> ready_o && !rvalid_o && !err_o) else $error("reset");
endmodule

bind swb_ctrl swb_ctrl_checker #(.SIZE_KB(SIZE_KB)) u_swb_ctrl_checker (.clk_i, .rst_i, .ce_i,
  .req_i, .req_data_i, .ready_o, .rvalid_o, .rdata_o, .err_o);

// ### test/swb_cpu_model.sv
/* Requester model; its tasks are called just after a rising edge. */
`timescale 1ns/10ps

module swb_cpu_model
  import swb_pkg::*;
(
  input wire logic clk_i,
  input wire logic err_i,
  input wire logic rvalid_i,
  input wire logic [31:0] rdata_i,
  output logic req_o,
  output swb_req_s req_data_o
);
  // --
  // Bus cycle
  // --
  initial req_o = 1'h0;
  initial req_data_o = '0;
  task automatic idle();
    req_o = 1'h0;
    req_data_o = ~req_data_o;
    @(posedge clk_i) #1;
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
    input swb_size_e s, output logic [31:0] q, output logic e);
    logic v;
    req_o = 1'h1;
    req_data_o = '{a, d, s, w};
    @(posedge clk_i) #1;
    e = err_i;
    q = rdata_i;
    v = rvalid_i;
    if (!w) begin
      req_o = 1'h0;
      req_data_o = ~req_data_o;
      @(posedge clk_i) #1;
      if (!e) begin
        q = rdata_i;
        v = rvalid_i;
      end
      e = e ^ !v;
    end
  endtask
endmodule

// ### test/tb.sv
/* Self-checking bench; model and checker compile first. */
`timescale 1ns/10ps

module tb
  import swb_pkg::*;
;
  // --
  // Harness
  // --
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic ce_i = 1'h1;
  logic req_i, ready_o, rvalid_o, err_o, e;
  swb_req_s req_data_i;
  logic [31:0] rdata_o, q;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #50 clk_i = ~clk_i;
  swb_ctrl #(.SIZE_KB(16)) u_swb_ctrl (.clk_i, .rst_i, .ce_i, .req_i, .req_data_i, .ready_o,
    .rvalid_o, .rdata_o, .err_o);
  swb_cpu_model u_swb_cpu_model (.clk_i, .err_i(err_o), .rvalid_i(rvalid_o),
    .rdata_i(rdata_o), .req_o(req_i), .req_data_o(req_data_i));
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done();
    end
  end
  // --
  // Tests
  // --
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      $display("MISMATCH %0t got %h want %h", $time, g, x);
      errors++;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input swb_size_e s);
    u_swb_cpu_model.acc(1'h1, a, d, s, q, e);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
    u_swb_cpu_model.acc(1'h0, a, 32'h0, SWB_WORD, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic t_lanes();
    wr(32'h10, 32'h44332211, SWB_WORD);
    wr(32'h11, 32'h123456AA, SWB_BYTE);
    wr(32'h13, 32'h5678BEEF, SWB_HALF);
    rd(32'h10, 32'hBEEFAA11, 1'h0);
    wr(32'h40, 32'h0, SWB_WORD);
    rd(32'h12, 32'hBEEFAA11, 1'h0);
    $display("lanes end");
  endtask
  task automatic t_hold();
    wr(32'h30, 32'h01020304, SWB_WORD);
    ce_i = 1'h0;
    wr(32'h10, 32'h0, SWB_WORD);
    u_swb_cpu_model.idle();
    ce_i = 1'h1;
    rd(32'h10, 32'hBEEFAA11, 1'h0);
    rd(32'h30, 32'h01020304, 1'h0);
    $display("hold end");
  endtask
  task automatic t_reset();
    wr(32'h20, 32'h11111111, SWB_WORD);
    wr(32'h20, 32'h22222222, SWB_WORD);
    u_swb_cpu_model.idle();
    rst_i = 1'h1;
    @(posedge clk_i) #1;
    rst_i = 1'h0;
    rd(32'h20, 32'h11111111, 1'h0);
    $display("reset end");
  endtask
  task automatic t_range();
    wr(32'h3FFC, 32'hCAFEF00D, SWB_WORD);
    wr(32'h4000, 32'h0, SWB_WORD);
    chk({31'h0, e}, 32'h1);
    rd(32'h4000, 32'h0, 1'h1);
    wr(32'h0, 32'h0, SWB_WORD);
    rd(32'h3FFC, 32'hCAFEF00D, 1'h0);
    $display("range end");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'h0;
    t_lanes();
    t_hold();
    t_reset();
    t_range();
    test_done();
  end
endmodule
